// [hw/dtei_pkg.sv]
// Shared constants and carrier types for the dual timer and external request block.
// Assumes an 8-bit register port and a single 125 MHz clock.
package dtei_pkg;

   // Register addresses on the plain register port
   localparam logic [7:0] ADDR_CTRL  = 8'h88;
   localparam logic [7:0] ADDR_MODE  = 8'h89;
   localparam logic [7:0] ADDR_TL0   = 8'h8A;
   localparam logic [7:0] ADDR_TL1   = 8'h8B;
   localparam logic [7:0] ADDR_TH0   = 8'h8C;
   localparam logic [7:0] ADDR_TH1   = 8'h8D;
   localparam logic [7:0] ADDR_PRESC = 8'h8E;

   // Field positions in timer_control_status
   localparam int unsigned CS_TF1 = 7;
   localparam int unsigned CS_TR1 = 6;
   localparam int unsigned CS_TF0 = 5;
   localparam int unsigned CS_TR0 = 4;
   localparam int unsigned CS_IE1 = 3;
   localparam int unsigned CS_IT1 = 2;
   localparam int unsigned CS_IE0 = 1;
   localparam int unsigned CS_IT0 = 0;

   // Field positions in timer_mode_reg
   localparam int unsigned MD_GATE1 = 7;
   localparam int unsigned MD_CT1   = 6;
   localparam int unsigned MD_M1_HI = 5;
   localparam int unsigned MD_M1_LO = 4;
   localparam int unsigned MD_GATE0 = 3;
   localparam int unsigned MD_CT0   = 2;
   localparam int unsigned MD_M0_HI = 1;
   localparam int unsigned MD_M0_LO = 0;

   // Field positions in clock_prescale_reg
   localparam int unsigned PS_T1 = 4;
   localparam int unsigned PS_T0 = 3;

   // Values after reset
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] MODE_RST  = 8'h00;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;

   // Prescaler ratio in clock cycles
   localparam int unsigned PRESC_DIV = 12;

   // Counting limits
   localparam logic [4:0]  M0_LOW_MAX = 5'h1F;
   localparam logic [7:0]  BYTE_MAX   = 8'hFF;
   localparam logic [15:0] WORD_MAX   = 16'hFFFF;

   // Mode encodings of the two mode-select bits
   localparam logic [1:0] MODE_13BIT  = 2'b00;
   localparam logic [1:0] MODE_16BIT  = 2'b01;
   localparam logic [1:0] MODE_RELOAD = 2'b10;
   localparam logic [1:0] MODE_SPLIT  = 2'b11;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dtei_bus_t;

   // Vectoring acknowledges from the processor core
   typedef struct packed {
      logic tf1;
      logic tf0;
      logic ie1;
      logic ie0;
   } dtei_ack_t;

   // One timer step result
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic       ovf;
   } dtei_cnt_t;

endpackage

// [hw/dtei_pin_sync.sv]
// Two-flop synchroniser with falling-edge detect for a group of input pins.
// Assumes pins idle high; the third stage only compares settled samples.
`timescale 1ns/1ps
module dtei_pin_sync
#(
   parameter int WIDTH = 4
)
(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] prev_r;

   // Sampling chain; reset to idle high so no false edge at release
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= '1;
         sync_r <= '1;
         prev_r <= '1;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Settled level and one-cycle falling-edge pulse
   assign level = sync_r;
   assign fall  = prev_r & ~sync_r;

endmodule

// [hw/dtei_top.sv]
// Timer zero and timer one with control/status, mode, prescale and count registers,
// plus two external request flags. Assumes inputs synchronous to mclk,
// idle-high request and count pins, and one-cycle vector acknowledges.
`timescale 1ns/1ps
module dtei_top
(
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire dtei_pkg::dtei_bus_t bus_req,
   output logic [7:0]              rd_data_r,
   input  wire dtei_pkg::dtei_ack_t vector_ack,
   input  wire logic               ext_req_zero_pin,
   input  wire logic               ext_req_one_pin,
   input  wire logic               count_in_zero_pin,
   input  wire logic               count_in_one_pin,
   output logic                    timer_zero_overflow_flag,
   output logic                    timer_one_overflow_flag,
   output logic                    ext_req_zero_flag,
   output logic                    ext_req_one_flag,
   output logic                    timer_one_baud_tick_r
);
   import dtei_pkg::*;

   logic [7:0] mode_r;
   logic [7:0] presc_r;
   logic [7:0] tl0_r;
   logic [7:0] th0_r;
   logic [7:0] tl1_r;
   logic [7:0] th1_r;
   logic       tf1_r;
   logic       tf0_r;
   logic       tr1_r;
   logic       tr0_r;
   logic       ie1_r;
   logic       ie0_r;
   logic       it1_r;
   logic       it0_r;
   logic [3:0] div_cnt_r;
   logic       div_en;
   logic [3:0] pin_level;
   logic [3:0] pin_fall;
   logic       ext_req_zero_pin_lvl;
   logic       ext_req_one_pin_lvl;
   logic       wr_ctrl;
   logic       wr_tl0;
   logic       wr_th0;
   logic       wr_tl1;
   logic       wr_th1;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic       split;
   logic       clk_tick0;
   logic       clk_tick1;
   logic       tick0;
   logic       tick1;
   logic       en0;
   logic       en0h;
   logic       en1;
   logic       ovf0;
   logic       ovf0h;
   logic       ovf1;
   logic       tf0_set;
   logic       tf1_set;
   dtei_cnt_t  step0;
   dtei_cnt_t  step1;

   // One count step of a timer in modes 0, 1 and 2; mode 3 holds
   function automatic dtei_cnt_t dtei_step(input logic [1:0] mode,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
      dtei_cnt_t r;
      r.high = hi;
      r.low  = lo;
      r.ovf  = 1'b0;
      case (mode)
         MODE_13BIT:
         begin
            // Upper three low-byte bits are left untouched
            if (lo[4:0] == M0_LOW_MAX)
            begin
               r.low  = {lo[7:5], 5'h00};
               r.high = hi + 8'h01;
               r.ovf  = (hi == BYTE_MAX);
            end
            else
            begin
               r.low = {lo[7:5], lo[4:0] + 5'h01};
            end
         end
         MODE_16BIT:
         begin
            {r.high, r.low} = {hi, lo} + 16'h0001;
            r.ovf = ({hi, lo} == WORD_MAX);
         end
         MODE_RELOAD:
         begin
            if (lo == BYTE_MAX)
            begin
               r.low = hi;
               r.ovf = 1'b1;
            end
            else
            begin
               r.low = lo + 8'h01;
            end
         end
         default:
         begin
            r.ovf = 1'b0;
         end
      endcase
      return r;
   endfunction

   // Pin synchronisers: bit 0 req zero, 1 req one, 2 count zero, 3 count one
   dtei_pin_sync
   #(
      .WIDTH (4)
   )
   u_pin_sync
   (
      .mclk   (mclk),
      .reset  (reset),
      .pin_in ({count_in_one_pin, count_in_zero_pin, ext_req_one_pin, ext_req_zero_pin}),
      .level  (pin_level),
      .fall   (pin_fall)
   );

   assign ext_req_zero_pin_lvl = pin_level[0];
   assign ext_req_one_pin_lvl = pin_level[1];

   // Register port write decode
   assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
   assign wr_tl0  = bus_req.wr && (bus_req.addr == ADDR_TL0);
   assign wr_th0  = bus_req.wr && (bus_req.addr == ADDR_TH0);
   assign wr_tl1  = bus_req.wr && (bus_req.addr == ADDR_TL1);
   assign wr_th1  = bus_req.wr && (bus_req.addr == ADDR_TH1);

   // Divide-by-12 enable pulse
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         div_cnt_r <= 4'h0;
      else if (div_en)
         div_cnt_r <= 4'h0;
      else
         div_cnt_r <= div_cnt_r + 4'h1;
   end
   assign div_en = (div_cnt_r == 4'(PRESC_DIV - 1));

   // Tick sources and run qualification
   assign mode0     = {mode_r[MD_M0_HI], mode_r[MD_M0_LO]};
   assign mode1     = {mode_r[MD_M1_HI], mode_r[MD_M1_LO]};
   assign split     = (mode0 == MODE_SPLIT);
   assign clk_tick0 = presc_r[PS_T0] | div_en;
   assign clk_tick1 = presc_r[PS_T1] | div_en;
   assign tick0     = mode_r[MD_CT0] ? pin_fall[2] : clk_tick0;
   assign tick1     = mode_r[MD_CT1] ? pin_fall[3] : clk_tick1;

   // A write to either count byte freezes that timer's counting for the cycle; in split each timer zero byte freezes alone
   assign en0  = tr0_r && (!mode_r[MD_GATE0] || ext_req_zero_pin_lvl) && tick0
                 && !wr_tl0 && (split || !wr_th0);
   assign en0h = split && tr1_r && clk_tick0 && !wr_th0;
   assign en1  = (split || tr1_r) && (!mode_r[MD_GATE1] || ext_req_one_pin_lvl) && tick1
                 && (mode1 != MODE_SPLIT) && !wr_tl1 && !wr_th1;

   assign step0 = dtei_step(mode0, th0_r, tl0_r);
   assign step1 = dtei_step(mode1, th1_r, tl1_r);

   // Overflow events
   assign ovf0    = en0 && (split ? (tl0_r == BYTE_MAX) : step0.ovf);
   assign ovf0h   = en0h && (th0_r == BYTE_MAX);
   assign ovf1    = en1 && step1.ovf;
   assign tf0_set = ovf0;
   assign tf1_set = split ? ovf0h : ovf1;

   // Mode and prescale registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         mode_r  <= MODE_RST;
         presc_r <= PRESC_RST;
      end
      else if (bus_req.wr && (bus_req.addr == ADDR_MODE))
         mode_r <= bus_req.wdata;
      else if (bus_req.wr && (bus_req.addr == ADDR_PRESC))
         presc_r <= bus_req.wdata & ((8'h01 << PS_T1) | (8'h01 << PS_T0));
   end

   // Timer zero count bytes
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tl0_r <= COUNT_RST;
         th0_r <= COUNT_RST;
      end
      else
      begin
         if (wr_tl0)
            tl0_r <= bus_req.wdata;
         else if (en0)
            tl0_r <= split ? tl0_r + 8'h01 : step0.low;
         if (wr_th0)
            th0_r <= bus_req.wdata;
         else if (en0h)
            th0_r <= th0_r + 8'h01;
         else if (en0 && !split)
            th0_r <= step0.high;
      end
   end

   // Timer one count bytes
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tl1_r <= COUNT_RST;
         th1_r <= COUNT_RST;
      end
      else
      begin
         if (wr_tl1)
            tl1_r <= bus_req.wdata;
         else if (en1)
            tl1_r <= step1.low;
         if (wr_th1)
            th1_r <= bus_req.wdata;
         else if (en1)
            th1_r <= step1.high;
      end
   end

   // Run and trigger-type bits
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tr1_r <= CTRL_RST[CS_TR1];
         tr0_r <= CTRL_RST[CS_TR0];
         it1_r <= CTRL_RST[CS_IT1];
         it0_r <= CTRL_RST[CS_IT0];
      end
      else if (wr_ctrl)
      begin
         tr1_r <= bus_req.wdata[CS_TR1];
         tr0_r <= bus_req.wdata[CS_TR0];
         it1_r <= bus_req.wdata[CS_IT1];
         it0_r <= bus_req.wdata[CS_IT0];
      end
   end

   // Overflow flags; hardware set wins over vector or software clear
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tf1_r <= CTRL_RST[CS_TF1];
         tf0_r <= CTRL_RST[CS_TF0];
      end
      else
      begin
         if (tf1_set)
            tf1_r <= 1'b1;
         else if (vector_ack.tf1)
            tf1_r <= 1'b0;
         else if (wr_ctrl)
            tf1_r <= bus_req.wdata[CS_TF1];
         if (tf0_set)
            tf0_r <= 1'b1;
         else if (vector_ack.tf0)
            tf0_r <= 1'b0;
         else if (wr_ctrl)
            tf0_r <= bus_req.wdata[CS_TF0];
      end
   end

   // External request one flag
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ie1_r <= CTRL_RST[CS_IE1];
      else if (!it1_r)
         ie1_r <= ~ext_req_one_pin_lvl;
      else if (pin_fall[1])
         ie1_r <= 1'b1;
      else if (vector_ack.ie1)
         ie1_r <= 1'b0;
      else if (wr_ctrl)
         ie1_r <= bus_req.wdata[CS_IE1];
   end

   // External request zero flag
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ie0_r <= CTRL_RST[CS_IE0];
      else if (!it0_r)
         ie0_r <= ~ext_req_zero_pin_lvl;
      else if (pin_fall[0])
         ie0_r <= 1'b1;
      else if (vector_ack.ie0)
         ie0_r <= 1'b0;
      else if (wr_ctrl)
         ie0_r <= bus_req.wdata[CS_IE0];
   end

   // Timer one overflow pulse for the baud path, also during split
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         timer_one_baud_tick_r <= 1'b0;
      else
         timer_one_baud_tick_r <= ovf1;
   end

   // Read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         rd_data_r <= 8'h00;
      else if (bus_req.rd)
      begin
         case (bus_req.addr)
            ADDR_CTRL:  rd_data_r <= {tf1_r, tr1_r, tf0_r, tr0_r, ie1_r, it1_r, ie0_r, it0_r};
            ADDR_MODE:  rd_data_r <= mode_r;
            ADDR_TL0:   rd_data_r <= tl0_r;
            ADDR_TH0:   rd_data_r <= th0_r;
            ADDR_TL1:   rd_data_r <= tl1_r;
            ADDR_TH1:   rd_data_r <= th1_r;
            ADDR_PRESC: rd_data_r <= presc_r;
            default:    rd_data_r <= 8'h00;
         endcase
      end
      else
         rd_data_r <= 8'h00;
   end

   // Flag outputs straight from their flops
   assign timer_one_overflow_flag  = tf1_r;
   assign timer_zero_overflow_flag = tf0_r;
   assign ext_req_one_flag         = ie1_r;
   assign ext_req_zero_flag        = ie0_r;

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence req1_fall_s;
      (it1_r && ext_req_one_pin) ##1 (it1_r && !ext_req_one_pin) [*3];
   endsequence

   sequence req0_low_s;
      (!it0_r && !ext_req_zero_pin) [*3];
   endsequence

   t0_wrap_flag_a: assert property (
      (mode0 == MODE_16BIT && en0 && tl0_r == BYTE_MAX && th0_r == BYTE_MAX)
      |=> (tf0_r && tl0_r == 8'h00 && th0_r == 8'h00))
      else $error("timer zero 16-bit wrap did not clear count and set flag");

   t1_vector_clr_a: assert property (
      (vector_ack.tf1 && !tf1_set) |=> !tf1_r)
      else $error("timer one flag not cleared by vector acknowledge");

   t0_stop_hold_a: assert property (
      (!tr0_r && !split && !wr_tl0 && !wr_th0) |=> ($stable(tl0_r) && $stable(th0_r)))
      else $error("timer zero counted while its run bit was clear");

   req1_edge_a: assert property (
      req1_fall_s |=> ie1_r)
      else $error("request one falling edge did not set its flag");

   req0_level_a: assert property (
      req0_low_s |=> ie0_r)
      else $error("request zero low level did not set its flag");

   t1_reload_a: assert property (
      (mode1 == MODE_RELOAD && en1 && tl1_r == BYTE_MAX)
      |=> (tl1_r == $past(th1_r) && tf1_r == !split))
      else $error("timer one reload value not loaded on overflow");

   t1_mode3_hold_a: assert property (
      (mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1_r, tl1_r}))
      else $error("timer one changed count in mode 3");

   split_no_tf1_a: assert property (
      (split && !tf1_r && !(en0h && th0_r == BYTE_MAX) && !wr_ctrl) |=> !tf1_r)
      else $error("timer one flag set during split by something other than high byte");

   m0_carry_a: assert property (
      (mode0 == MODE_13BIT && en0 && tl0_r[4:0] == M0_LOW_MAX && th0_r != BYTE_MAX)
      |=> (tl0_r[4:0] == 5'h00 && th0_r == $past(th0_r) + 8'h01))
      else $error("mode 0 low five bits did not carry into high byte");

   gate_block_a: assert property (
      (mode_r[MD_GATE0] && !ext_req_zero_pin_lvl && !split && !wr_tl0 && !wr_th0) |=> $stable(tl0_r))
      else $error("gated timer zero counted with its request pin low");

   gate_one_block_a: assert property (
      (mode_r[MD_GATE1] && !ext_req_one_pin_lvl && !wr_tl1 && !wr_th1) |=> $stable({th1_r, tl1_r}))
      else $error("gated timer one counted with its request pin low");

   rd_tl1_a: assert property (
      (bus_req.rd && bus_req.addr == ADDR_TL1) |=> (rd_data_r == $past(tl1_r)))
      else $error("read data do not show the timer one low byte");

endmodule

// [testbench/dtei_far_model.sv]
// Far side of the block: request and count pins, and the core's vectoring pulses.
// Assumes the bench sets pin levels and acknowledge enables; pins idle high.
`timescale 1ns/1ps
module dtei_far_model
(
   input  wire logic           mclk,
   input  wire logic           reset,
   input  wire logic [1:0]     req_lvl,
   input  wire logic [1:0]     cnt_lvl,
   input  wire logic [3:0]     ack_en,
   input  wire logic           ack_slow,
   input  wire logic [3:0]     flags,
   output logic                ext_req_zero_pin,
   output logic                ext_req_one_pin,
   output logic                count_in_zero_pin,
   output logic                count_in_one_pin,
   output dtei_pkg::dtei_ack_t vector_ack
);
   import dtei_pkg::*;
   logic [3:0] ack_v;
   int         wait_c [4];

   // Pins change only just after a rising edge, idle high in reset
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         {ext_req_one_pin, ext_req_zero_pin}   <= 2'b11;
         {count_in_one_pin, count_in_zero_pin} <= 2'b11;
      end
      else
      begin
         {ext_req_one_pin, ext_req_zero_pin}   <= req_lvl;
         {count_in_one_pin, count_in_zero_pin} <= cnt_lvl;
      end
   end

   // Vector to a routine two or seven cycles after its flag is seen
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ack_v <= 4'h0;
         for (int i = 0; i < 4; i++)
            wait_c[i] <= 0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            ack_v[i] <= 1'b0;
            wait_c[i] <= 0;
            if (ack_en[i] && flags[i] === 1'b1 && !ack_v[i])
            begin
               wait_c[i] <= wait_c[i] + 1;
               if (wait_c[i] >= (ack_slow ? 6 : 1))
               begin
                  ack_v[i]  <= 1'b1;
                  wait_c[i] <= 0;
               end
            end
         end
      end
   end

   // Pulse order matches the acknowledge struct
   assign vector_ack = dtei_ack_t'(ack_v);
endmodule

// [testbench/dtei_top_tb.sv]
// Self-checking bench for the timer pair and the two request flags.
// Assumes the far-side model drives every pin and vectoring pulse.
`timescale 1ns/1ps
module dtei_top_tb;
   import dtei_pkg::*;
   logic       mclk;
   logic       reset;
   dtei_bus_t  bus_req;
   logic [7:0] rd_data_r;
   dtei_ack_t  vector_ack;
   logic       req0, req1, cnt0, cnt1;
   logic       tf0, tf1, ie0, ie1, baud;
   logic [1:0] req_lvl, cnt_lvl;
   logic [3:0] ack_en;
   logic       ack_slow;
   logic [4:0] obs;
   int         mismatches;
   int         tests_run;

   assign obs = {baud, tf1, tf0, ie1, ie0};

   // Clock, 8 ns period
   always #4 mclk = ~mclk;

   dtei_top i_dut
   (
      .mclk                     (mclk),
      .reset                    (reset),
      .bus_req                  (bus_req),
      .rd_data_r                (rd_data_r),
      .vector_ack               (vector_ack),
      .ext_req_zero_pin         (req0),
      .ext_req_one_pin          (req1),
      .count_in_zero_pin        (cnt0),
      .count_in_one_pin         (cnt1),
      .timer_zero_overflow_flag (tf0),
      .timer_one_overflow_flag  (tf1),
      .ext_req_zero_flag        (ie0),
      .ext_req_one_flag         (ie1),
      .timer_one_baud_tick_r    (baud)
   );

   dtei_far_model i_far
   (
      .mclk              (mclk),
      .reset             (reset),
      .req_lvl           (req_lvl),
      .cnt_lvl           (cnt_lvl),
      .ack_en            (ack_en),
      .ack_slow          (ack_slow),
      .flags             (obs[3:0]),
      .ext_req_zero_pin  (req0),
      .ext_req_one_pin   (req1),
      .count_in_zero_pin (cnt0),
      .count_in_one_pin  (cnt1),
      .vector_ack        (vector_ack)
   );

   // Verdict and end of run
   task automatic stop_test;
      $display("Compares %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Byte and flag comparisons
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Register port cycles
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      bus_req.wr    <= 1'b1;
      @(posedge mclk);
      bus_req.wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus_req.addr <= a;
      bus_req.rd   <= 1'b1;
      @(posedge mclk);
      bus_req.rd   <= 1'b0;
      #1;
      d = rd_data_r;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] v;
      rd_reg(a, v);
      chk8(nm, e, v);
   endtask

   // Bounded wait for one observed output bit
   task automatic wait_obs(input int b, input logic v, input int bound, output int n);
      n = 0;
      #1;
      while (obs[b] !== v && n < bound)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (obs[b] !== v)
      begin
         mismatches++;
         $display("MISMATCH wait on output %0d expected %b seen %b", b, v, obs[b]);
         stop_test();
      end
   endtask

   task automatic rst_dut;
      @(posedge mclk);
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
   endtask

   task automatic pulse_cnt(input int i, input int cnt);
      repeat (cnt)
      begin
         @(posedge mclk);
         cnt_lvl[i] <= 1'b0;
         repeat (3) @(posedge mclk);
         cnt_lvl[i] <= 1'b1;
         repeat (3) @(posedge mclk);
      end
   endtask

   task automatic t_regs;
      rst_dut();
      for (int i = 0; i < 7; i++)
         rd_chk(ADDR_CTRL + 8'(i), 8'h00, "reset value");
      wr_reg(8'h80, 8'hA5);
      rd_chk(8'h80, 8'h00, "unmapped");
      wr_reg(ADDR_PRESC, 8'hFF);
      rd_chk(ADDR_PRESC, 8'h18, "prescale bits");
      $display("test registers done");
   endtask

   task automatic run_mode(input int t, input logic [1:0] m, input logic [7:0] tl,
                           input logic [7:0] th, input logic [7:0] eth);
      logic [7:0] v;
      int         n;
      rst_dut();
      wr_reg(ADDR_PRESC, 8'h08 << t);
      wr_reg(ADDR_TL0 + 8'(t), tl);
      wr_reg(ADDR_TH0 + 8'(t), th);
      wr_reg(ADDR_MODE, {6'h00, m} << (4 * t));
      repeat (20) @(posedge mclk);
      #1;
      chk1("flag while stopped", 1'b0, obs[2 + t]);
      wr_reg(ADDR_CTRL, 8'h10 << (2 * t));
      wait_obs(2 + t, 1'b1, 10, n);
      // Stop the timer but write its flag back as one, so only the vector clears it
      wr_reg(ADDR_CTRL, 8'h20 << (2 * t));
      rd_chk(ADDR_TH0 + 8'(t), eth, "high byte after wrap");
      rd_reg(ADDR_TL0 + 8'(t), v);
      // Upper low-byte bits are masked as software must in mode 0
      chk1("low byte after wrap", 1'b1,
           (m == MODE_RELOAD) ? (v >= th) : ((v & 8'h1F) < 8'h08));
      chk1("flag stands until vector", 1'b1, obs[2 + t]);
      ack_en <= 4'b0100 << t;
      wait_obs(2 + t, 1'b0, 20, n);
      ack_en <= 4'h0;
      $display("test mode %0d timer %0d done", m, t);
   endtask

   task automatic t_presc;
      int n;
      rst_dut();
      wr_reg(ADDR_TL1, 8'hFE);
      wr_reg(ADDR_TH1, 8'hFF);
      wr_reg(ADDR_MODE, 8'h10);
      wr_reg(ADDR_CTRL, 8'h40);
      wait_obs(3, 1'b1, 40, n);
      chk1("divided tick spacing", 1'b1, n >= 10);
      $display("test prescale done");
   endtask

   task automatic t_count;
      int n;
      rst_dut();
      // Both request pins low before the run bits, so both gates start shut
      req_lvl <= 2'b00;
      wr_reg(ADDR_TL1, 8'hFD);
      wr_reg(ADDR_TH1, 8'hFF);
      wr_reg(ADDR_MODE, 8'hDC);
      wr_reg(ADDR_CTRL, 8'h50);
      pulse_cnt(1, 3);
      pulse_cnt(0, 2);
      chk1("gated count", 1'b0, obs[3]);
      rd_chk(ADDR_TL0, 8'h00, "gated counter zero");
      req_lvl <= 2'b11;
      repeat (4) @(posedge mclk);
      pulse_cnt(0, 2);
      rd_chk(ADDR_TL0, 8'h02, "counter zero edges");
      pulse_cnt(1, 2);
      chk1("two edges short", 1'b0, obs[3]);
      pulse_cnt(1, 1);
      wait_obs(3, 1'b1, 10, n);
      $display("test counter done");
   endtask

   task automatic t_split;
      int n;
      rst_dut();
      wr_reg(ADDR_PRESC, 8'h08);
      wr_reg(ADDR_MODE, 8'h33);
      wr_reg(ADDR_TL0, 8'hFF);
      wr_reg(ADDR_TH0, 8'hFF);
      wr_reg(ADDR_TL1, 8'h12);
      wr_reg(ADDR_TH1, 8'h34);
      wr_reg(ADDR_CTRL, 8'h50);
      wait_obs(2, 1'b1, 10, n);
      wait_obs(3, 1'b1, 10, n);
      wr_reg(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_TL1, 8'h12, "held low byte");
      rd_chk(ADDR_TH1, 8'h34, "held high byte");
      // Timer one keeps counting under split but owns no flag
      rst_dut();
      wr_reg(ADDR_PRESC, 8'h18);
      wr_reg(ADDR_TH1, 8'hFF);
      wr_reg(ADDR_TL1, 8'hFF);
      wr_reg(ADDR_MODE, 8'h13);
      wait_obs(4, 1'b1, 10, n);
      repeat (2) @(posedge mclk);
      #1;
      chk1("split leaves flag", 1'b0, obs[3]);
      $display("test split done");
   endtask

   task automatic t_edge;
      int n;
      rst_dut();
      wr_reg(ADDR_CTRL, 8'h05);
      for (int i = 0; i < 2; i++)
      begin
         req_lvl[i] <= 1'b0;
         repeat (3) @(posedge mclk);
         req_lvl[i] <= 1'b1;
         wait_obs(i, 1'b1, 10, n);
         ack_en <= 4'b0001 << i;
         ack_slow <= (i == 1);
         wait_obs(i, 1'b0, 20, n);
         ack_en <= 4'h0;
         req_lvl[i] <= 1'b0;
         repeat (3) @(posedge mclk);
         req_lvl[i] <= 1'b1;
         wait_obs(i, 1'b1, 10, n);
         wr_reg(ADDR_CTRL, 8'h05);
         rd_chk(ADDR_CTRL, 8'h05, "flag cleared by write");
      end
      $display("test edge requests done");
   endtask

   task automatic t_level;
      int n;
      rst_dut();
      req_lvl <= 2'b00;
      wait_obs(0, 1'b1, 10, n);
      wait_obs(1, 1'b1, 10, n);
      wr_reg(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_CTRL, 8'h0A, "level flags pins low");
      req_lvl <= 2'b11;
      wait_obs(0, 1'b0, 10, n);
      wait_obs(1, 1'b0, 10, n);
      wr_reg(ADDR_CTRL, 8'h0A);
      rd_chk(ADDR_CTRL, 8'h00, "level flags pins high");
      $display("test level requests done");
   endtask

   // Main sequence
   initial
   begin
      mclk       = 1'b0;
      reset      = 1'b1;
      bus_req    = '0;
      req_lvl    = 2'b11;
      cnt_lvl    = 2'b11;
      ack_en     = 4'h0;
      ack_slow   = 1'b0;
      mismatches = 0;
      tests_run  = 0;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      t_regs();
      for (int t = 0; t < 2; t++)
      begin
         run_mode(t, MODE_13BIT, 8'h1E, 8'hFF, 8'h00);
         run_mode(t, MODE_16BIT, 8'hFE, 8'hFF, 8'h00);
         run_mode(t, MODE_RELOAD, 8'hFE, 8'hC8, 8'hC8);
      end
      t_presc();
      t_count();
      t_split();
      t_edge();
      t_level();
      stop_test();
   end
endmodule
